// >>> tb/touch_slider_event_control_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
  end \
end
module touch_slider_event_control_test;
  import tse_pkg::*;
  localparam int POLL = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [6:0] gtouch = 7'h00;
  logic [6:0] press = 7'h00;
  logic [6:0] rel = 7'h00;
  logic [1:0] tap = 2'h0;
  logic [1:0] hold = 2'h0;
  logic flag_clr = 1'b0;
  tse_noise_t noise = '{rf: 8'h11, lf: 8'h22};
  logic cal_rf = 1'b1;
  logic [10:0] pol = 11'h000;
  logic mir_wr = 1'b0;
  logic [10:0] mir_wd = 11'h000;
  logic slow = 1'b1;
  logic [3:0] slrpt = 4'h2;
  logic [7:0] rdata, recal_done, recal_req, nstat, tblock;
  logic rvalid, irq, up, down, tapf, phf, retry, inv, eq, gsl;
  logic [6:0] btn2, qsel;
  logic [10:0] mirror;
  int n_fail = 0;
  int checked = 0;
  int irq_cnt = 0;

  tse_event_ctrl #(.POLL_CYC(POLL)) i_tse_event_ctrl (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .GROUP_TOUCH_I(gtouch),
    .BTN_PRESS_I(press), .BTN_RELEASE_I(rel), .BTN_REPEAT_I(7'h00),
    .TAP_I(tap), .HOLD_I(hold), .SLIDER_RPT_POLLS_I(slrpt),
    .GROUP_RPT_POLLS_I(4'hf), .FLAG_CLR_I(flag_clr),
    .RECAL_DONE_I(recal_done), .NOISE_I(noise), .CAL_RF_I(cal_rf),
    .LED_POL_I(pol), .MIRROR_WR_I(mir_wr), .MIRROR_WDATA_I(mir_wd),
    .IRQ_O(irq), .BTN2_STATUS_O(btn2), .UP_FLAG_O(up),
    .DOWN_FLAG_O(down), .TAP_FLAG_O(tapf), .PRESS_HOLD_FLAG_O(phf),
    .RECAL_REQ_O(recal_req), .NOISE_STATUS_O(nstat),
    .TOUCH_BLOCK_O(tblock), .CAL_RETRY_O(retry), .LED_MIRROR_O(mirror),
    .LINK_INVERT_O(inv), .LINK_MIN_EQ_MAX_O(eq), .GROUP_SLIDER_O(gsl),
    .GROUP_QUEUE_SEL_O(qsel)
  );

  tse_recal_model i_tse_recal_model (
    .clk_i(clk), .rst_n_i(rst_n), .req_i(recal_req), .slow_i(slow),
    .done_o(recal_done)
  );

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end

  task automatic complete_run;
    $display("Counts: %0d checked, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic done_test(input string nm);
    $display("Test %s finished, %0d mismatches so far", nm, n_fail);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    // The valid pulse stands only until the next rising edge.
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask

  // Counts interrupt pulses over a window that opens with a one-cycle event.
  task automatic evt(input logic [6:0] p, input logic [6:0] r,
                     input logic [1:0] t, input logic [1:0] h, input int e);
    int m;
    @(negedge clk);
    m = irq_cnt;
    press = p;
    rel = r;
    tap = t;
    hold = h;
    @(negedge clk);
    press = 7'h00;
    rel = 7'h00;
    tap = 2'h0;
    hold = 2'h0;
    repeat (3) @(negedge clk);
    if (e >= 0) `CHK("irq count", e, irq_cnt - m)
  endtask

  task automatic touch_win(input logic [6:0] g, input int e);
    int m;
    @(negedge clk);
    m = irq_cnt;
    gtouch = g;
    repeat (4) @(negedge clk);
    `CHK("touch irq count", e, irq_cnt - m)
  endtask

  task automatic recal(input logic [7:0] v, input logic s);
    slow = s;
    wr(ADDR_RECAL, v);
    `CHK("recal pending", v, recal_req)
    if (s) rd(ADDR_RECAL, v);
    for (int i = 0; i < 40 && recal_req !== 8'h00; i++) @(negedge clk);
    `CHK("recal cleared", 8'h00, recal_req)
    rd(ADDR_RECAL, 8'h00);
  endtask

  task automatic cfg_case(input logic [7:0] c, input logic [7:0] ns,
                          input logic [7:0] tb, input logic rt,
                          input logic iv, input logic mq,
                          input logic gs, input logic [6:0] qs);
    wr(ADDR_CFG2, c);
    repeat (2) @(negedge clk);
    `CHK("noise status", ns, nstat)
    `CHK("touch block", tb, tblock)
    `CHK("cal retry", rt, retry)
    `CHK("link invert", iv, inv)
    `CHK("link min eq max", mq, eq)
    `CHK("group slider", gs, gsl)
    `CHK("queue select", qs, qsel)
  endtask

  // A sweep across all seven grouped sensors, then release.
  task automatic slide(input logic [7:0] v, input int dwell, input int e);
    int m;
    wr(ADDR_SLIDER, v);
    for (int i = 0; i < 7; i++) begin
      gtouch = 7'h01 << i;
      repeat (dwell) @(negedge clk);
    end
    gtouch = 7'h00;
    @(negedge clk);
    m = irq_cnt;
    repeat (12 * POLL) @(negedge clk);
    `CHK("extra irq count", e, irq_cnt - m)
  endtask

  // One sensor held: the start interrupt, then one per programmed period.
  // The window spans eight or nine polling ticks, so the count is exact.
  task automatic hold_rpt(input logic [3:0] per, input int e);
    int m;
    slrpt = per;
    wr(ADDR_SLIDER, 8'h45);
    m = irq_cnt;
    gtouch = 7'h08;
    repeat (8 * POLL + POLL / 2) @(negedge clk);
    `CHK("repeat irq count", e, irq_cnt - m)
    gtouch = 7'h00;
    @(negedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK("min eq max at reset", 1'b1, eq)
    `CHK("slider at reset", 1'b1, gsl)
    rd(ADDR_SLIDER, RST_SLIDER);
    rd(ADDR_RECAL, RST_RECAL);
    rd(ADDR_CFG2, RST_CFG2);
    rd(8'h41, RDATA_UNMAPPED);
    wr(ADDR_CFG2, 8'hff);
    rd(ADDR_CFG2, 8'h9f);
    done_test("registers");
    recal(8'h81, 1'b1);
    recal(8'h7e, 1'b0);
    done_test("recalibration");
    cfg_case(8'h00, 8'h33, 8'h33, 1'b1, 1'b0, 1'b1, 1'b1, 7'h00);
    cfg_case(8'h08, 8'h11, 8'h33, 1'b1, 1'b0, 1'b1, 1'b1, 7'h00);
    cfg_case(8'h04, 8'h33, 8'h22, 1'b0, 1'b0, 1'b1, 1'b1, 7'h00);
    cfg_case(8'h80, 8'h33, 8'h33, 1'b1, 1'b1, 1'b0, 1'b1, 7'h00);
    cfg_case(8'h02, 8'h33, 8'h33, 1'b1, 1'b0, 1'b1, 1'b0, 7'h3e);
    done_test("configuration");
    wr(ADDR_CFG2, 8'h00);
    pol = 11'h005;
    repeat (2) @(negedge clk);
    `CHK("mirror follows", 11'h005, mirror)
    wr(ADDR_CFG2, 8'h10);
    pol = 11'h000;
    repeat (2) @(negedge clk);
    `CHK("mirror held", 11'h005, mirror)
    mir_wd = 11'h7ff;
    mir_wr = 1'b1;
    @(negedge clk);
    mir_wr = 1'b0;
    @(negedge clk);
    `CHK("mirror written", 11'h7ff, mirror)
    done_test("mirror");
    wr(ADDR_CFG2, 8'h02);
    touch_win(7'h08, 1);
    `CHK("btn2 status", 7'h08, btn2)
    `CHK("no up from middle", 1'b0, up)
    `CHK("no tap from middle", 1'b0, tapf)
    touch_win(7'h01, 1);
    touch_win(7'h00, 0);
    evt(7'h00, 7'h00, 2'h1, 2'h0, -1);
    `CHK("down flag", 1'b1, down)
    `CHK("tap flag", 1'b1, tapf)
    `CHK("up stays clear", 1'b0, up)
    evt(7'h00, 7'h00, 2'h0, 2'h2, -1);
    `CHK("up flag", 1'b1, up)
    `CHK("hold flag", 1'b1, phf)
    flag_clr = 1'b1;
    @(negedge clk);
    flag_clr = 1'b0;
    @(negedge clk);
    `CHK("flags cleared", 5'h00, {btn2[3], up, down, tapf, phf})
    done_test("separate mode");
    wr(ADDR_CFG2, 8'h00);
    evt(7'h01, 7'h00, 2'h0, 2'h0, 1);
    evt(7'h00, 7'h01, 2'h0, 2'h0, 1);
    wr(ADDR_CFG2, 8'h01);
    evt(7'h00, 7'h01, 2'h0, 2'h0, 0);
    evt(7'h01, 7'h00, 2'h0, 2'h0, 1);
    done_test("release interrupts");
    slide(8'hc5, 5, 4);
    slide(8'h45, 5, 0);
    slide(8'ha5, 5, 2);
    slide(8'hc5, 4 * POLL, 0);
    slide(8'hcd, 4 * POLL, 1);
    done_test("slider extras");
    hold_rpt(4'h2, 5);
    hold_rpt(4'h4, 3);
    done_test("slider repeat");
    complete_run();
  end
endmodule

// >>> tb/tse_recal_model.sv
`timescale 1ns/1ps
// Stands in for the calibration engine behind the forced recalibration bits.
// The slow setting stretches the routine so a pending bit can be read back.
module tse_recal_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Requests in, completions out.
  input wire logic [7:0] req_i,
  input wire logic slow_i,
  output logic [7:0] done_o
);
  logic [3:0] cnt_r;
  logic [3:0] lim;

  assign lim = slow_i ? 4'hc : 4'h2;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || req_i == 8'h00) begin
      cnt_r <= 4'h0;
      done_o <= 8'h00;
    end else begin
      cnt_r <= (cnt_r == lim) ? 4'h0 : cnt_r + 4'h1;
      // Only bits that are really pending are reported finished.
      done_o <= (cnt_r == lim) ? req_i : 8'h00;
    end
  end
endmodule

// >>> verilog/tse_event_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Accel enable set gives extra slide interrupts; clear gives none.
// - Three-bit maximum field caps extra interrupts per slide, reset 100b.
// - Slide time field sets longest slide earning extras: 350/560/770/980ms.
// - Slide speed is grouped sensors touched within about 100 ms.
// - Repeat scale picks slider repeat period from sensor count table.
// - Scale 11b uses fixed 140/105/70 ms when programmed rate <= 105 ms.
// - Repeat rate counts polling cycles between generated interrupts.
// - Writing one to recal bit recalibrates; bit self-clears when done.
// - Recal bit 7 is grouped sensors, bits 6..0 sensors seven..one.
// - Invert bit: clear forces min duty to max, set inverts touch.
// - Decouple clear makes mirror bits follow polarity bits; set holds.
// - RF-only bit set limits noise status to RF noise.
// - Block-disable clear: RF noise blocks touch and retries calibration.
// - Grouped mode clear: seven grouped sensors act as one slider.
// - Separate mode: own interrupt and status; middle five set no flags.
// - Separate mode: middle sensors use button queue; ends use group rate.
// - End sensors interrupt on touch and repeat; never on release.
// - First end sensor sets down, last sets up; tap and hold normal.
// - Release suppress clear interrupts on release too; set does not.
module tse_event_ctrl #(
  parameter int POLL_CYC = tse_pkg::POLL_CYCLES
) (
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // Register port from the serial interface engine.
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Touch detection results.
  input wire logic [6:0] GROUP_TOUCH_I,
  input wire logic [6:0] BTN_PRESS_I,
  input wire logic [6:0] BTN_RELEASE_I,
  input wire logic [6:0] BTN_REPEAT_I,
  input wire logic [1:0] TAP_I,
  input wire logic [1:0] HOLD_I,
  input wire logic [3:0] SLIDER_RPT_POLLS_I,
  input wire logic [3:0] GROUP_RPT_POLLS_I,
  input wire logic FLAG_CLR_I,
  // Calibration and noise.
  input wire logic [7:0] RECAL_DONE_I,
  input wire tse_pkg::tse_noise_t NOISE_I,
  input wire logic CAL_RF_I,
  // LED linkage.
  input wire logic [10:0] LED_POL_I,
  input wire logic MIRROR_WR_I,
  input wire logic [10:0] MIRROR_WDATA_I,
  // Events and status.
  output logic IRQ_O,
  output logic [6:0] BTN2_STATUS_O,
  output logic UP_FLAG_O,
  output logic DOWN_FLAG_O,
  output logic TAP_FLAG_O,
  output logic PRESS_HOLD_FLAG_O,
  // Calibration, noise and mode controls.
  output logic [7:0] RECAL_REQ_O,
  output logic [7:0] NOISE_STATUS_O,
  output logic [7:0] TOUCH_BLOCK_O,
  output logic CAL_RETRY_O,
  output logic [10:0] LED_MIRROR_O,
  output logic LINK_INVERT_O,
  output logic LINK_MIN_EQ_MAX_O,
  output logic GROUP_SLIDER_O,
  output logic [6:0] GROUP_QUEUE_SEL_O
);
  import tse_pkg::*;

  localparam int PW = $clog2(POLL_CYC);

  function automatic logic [SLIDE_CNT_W-1:0] slide_limit(logic [1:0] s);
    int ms;
    unique case (s)
      2'b00: ms = SLIDE_00_MS;
      2'b01: ms = SLIDE_01_MS;
      2'b10: ms = SLIDE_10_MS;
      2'b11: ms = SLIDE_11_MS;
    endcase
    return SLIDE_CNT_W'(ms / POLL_MS);
  endfunction

  // Fast slides earn the full count, slower bands a half and a quarter.
  function automatic logic [2:0] extra_count(logic [2:0] mx,
      logic [SLIDE_CNT_W-1:0] t, logic [SLIDE_CNT_W-1:0] lim);
    logic [7:0] t4;
    logic [7:0] l4;
    t4 = {2'b00, t} << 2;
    l4 = {2'b00, lim};
    if (t > lim) return 3'h0;
    if (t4 < 8'(l4 * 2)) return mx;
    if (t4 < 8'(l4 * 3)) return mx >> 1;
    return mx >> 2;
  endfunction

  // Multiplier of the base period is max(1, scale + 3 - sensors).
  function automatic logic [RPT_W-1:0] rpt_polls(logic [1:0] sc,
      logic [SPEED_W-1:0] n, logic [RPT_W-1:0] prog);
    int m;
    logic [RPT_W-1:0] p;
    p = (prog == '0) ? RPT_W'(1) : prog;
    m = int'(sc) + 3 - int'(n);
    if (m < 1) m = 1;
    if (n < 4'h2) return p;
    // Five or more sensors keep the base period on every scale.
    if (sc == 2'b11 && p > RPT_W'(FAST_LIMIT_POLLS) && n < 4'h5) return p;
    return RPT_W'(m * RPT_BASE_POLLS);
  endfunction

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  tse_slider_cfg_t slider_cfg_r;
  tse_cfg2_t cfg2_r;
  logic [7:0] recal_r;
  logic [7:0] recal_nxt;
  logic wr_slider;
  logic wr_recal;
  logic wr_cfg2;

  assign wr_slider = REG_WR_I && REG_ADDR_I == ADDR_SLIDER;
  assign wr_recal = REG_WR_I && REG_ADDR_I == ADDR_RECAL;
  assign wr_cfg2 = REG_WR_I && REG_ADDR_I == ADDR_CFG2;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      slider_cfg_r <= RST_SLIDER;
      cfg2_r <= RST_CFG2;
    end else begin
      if (wr_slider) slider_cfg_r <= REG_WDATA_I;
      if (wr_cfg2) cfg2_r <= REG_WDATA_I & CFG2_MASK;
    end
  end

  // A request written in the cycle its routine finishes stays pending.
  always_comb begin
    recal_nxt = recal_r & ~RECAL_DONE_I;
    if (wr_recal) recal_nxt = recal_nxt | REG_WDATA_I;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) recal_r <= RST_RECAL;
    else recal_r <= recal_nxt;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= RDATA_UNMAPPED;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        unique case (REG_ADDR_I)
          ADDR_SLIDER: REG_RDATA_O <= slider_cfg_r;
          ADDR_RECAL: REG_RDATA_O <= recal_r;
          ADDR_CFG2: REG_RDATA_O <= cfg2_r;
          default: REG_RDATA_O <= RDATA_UNMAPPED;
        endcase
      end
    end
  end

  assign RECAL_REQ_O = recal_r;

  // Polling cycle timer; every slider count runs in these ticks.
  logic [PW-1:0] poll_cnt_r;
  logic poll_tick_r;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      poll_cnt_r <= '0;
      poll_tick_r <= 1'b0;
    end else begin
      poll_tick_r <= poll_cnt_r == PW'(POLL_CYC - 1);
      if (poll_cnt_r == PW'(POLL_CYC - 1)) poll_cnt_r <= '0;
      else poll_cnt_r <= poll_cnt_r + 1'b1;
    end
  end

  // Touch edges of the grouped sensors.
  logic [6:0] touch_q_r;
  logic [6:0] rise;
  logic [6:0] fall;
  logic slide_act;
  logic slide_q_r;
  logic slide_start;
  logic slide_end;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      touch_q_r <= '0;
      slide_q_r <= 1'b0;
    end else begin
      touch_q_r <= GROUP_TOUCH_I;
      slide_q_r <= slide_act;
    end
  end

  assign rise = GROUP_TOUCH_I & ~touch_q_r;
  assign fall = ~GROUP_TOUCH_I & touch_q_r;
  assign slide_act = |GROUP_TOUCH_I && !cfg2_r.group_separate_mode;
  assign slide_start = slide_act && !slide_q_r;
  assign slide_end = !slide_act && slide_q_r;

  // Slide speed: new touches counted per window of about 100 ms.
  logic [3:0] win_cnt_r;
  logic [SPEED_W-1:0] sens_cnt_r;
  logic [SPEED_W-1:0] speed_r;
  logic [SPEED_W-1:0] sens_sum;

  assign sens_sum = sens_cnt_r + SPEED_W'($countones(rise));

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      win_cnt_r <= '0;
      sens_cnt_r <= '0;
      speed_r <= '0;
    end else if (poll_tick_r &&
        win_cnt_r == 4'(SPEED_WIN_POLLS - 1)) begin
      win_cnt_r <= '0;
      speed_r <= slide_act ? sens_sum : '0;
      sens_cnt_r <= '0;
    end else begin
      if (poll_tick_r) win_cnt_r <= win_cnt_r + 1'b1;
      if (slide_act) sens_cnt_r <= sens_sum;
    end
  end

  // Slide duration and the extra interrupts that a fast slide earns.
  logic [SLIDE_CNT_W-1:0] slide_t_r;
  logic [2:0] extra_cnt_r;
  logic ev_extra;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) slide_t_r <= '0;
    else if (slide_start) slide_t_r <= '0;
    else if (slide_act && poll_tick_r && !(&slide_t_r))
      slide_t_r <= slide_t_r + 1'b1;
  end

  assign ev_extra = poll_tick_r && extra_cnt_r != '0;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) extra_cnt_r <= '0;
    else if (!slider_cfg_r.accel_extra_irq_enable) extra_cnt_r <= '0;
    else if (slide_end)
      extra_cnt_r <= extra_count(slider_cfg_r.max_extra, slide_t_r,
        slide_limit(slider_cfg_r.slide_time));
    else if (ev_extra) extra_cnt_r <= extra_cnt_r - 1'b1;
  end

  // Slider repeat: period in polling cycles chosen from the speed.
  logic [RPT_W-1:0] rpt_per;
  logic [RPT_W-1:0] rpt_cnt_r;
  logic ev_slide_rpt;

  assign rpt_per = rpt_polls(slider_cfg_r.repeat_speed_scale, speed_r,
    SLIDER_RPT_POLLS_I);
  assign ev_slide_rpt = slide_act && !slide_start && poll_tick_r &&
    rpt_cnt_r + 1'b1 >= rpt_per;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) rpt_cnt_r <= '0;
    else if (slide_start || ev_slide_rpt) rpt_cnt_r <= '0;
    else if (slide_act && poll_tick_r) rpt_cnt_r <= rpt_cnt_r + 1'b1;
  end

  // End sensors in separate mode repeat at the group rate while held.
  logic [RPT_W-1:0] end_cnt_r [2];
  logic [1:0] end_touch;
  logic [1:0] end_rise;
  logic [1:0] ev_end_rpt;
  logic [RPT_W-1:0] grp_per;

  assign end_touch = {GROUP_TOUCH_I[LAST_IDX], GROUP_TOUCH_I[FIRST_IDX]};
  assign end_rise = {rise[LAST_IDX], rise[FIRST_IDX]};
  assign grp_per = (GROUP_RPT_POLLS_I == '0) ? RPT_W'(1) : GROUP_RPT_POLLS_I;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ev_end_rpt[i] = cfg2_r.group_separate_mode && end_touch[i] &&
        !end_rise[i] && poll_tick_r &&
        end_cnt_r[i] + 1'b1 >= grp_per;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    for (int i = 0; i < 2; i++) begin
      if (!RESET_N_I) end_cnt_r[i] <= '0;
      else if (end_rise[i] || ev_end_rpt[i] || !end_touch[i])
        end_cnt_r[i] <= '0;
      else if (poll_tick_r) end_cnt_r[i] <= end_cnt_r[i] + 1'b1;
    end
  end

  // Interrupt events from every source.
  logic ev_btn;
  logic ev_rel;
  logic ev_grp;
  logic ev_slide;

  assign ev_rel = !cfg2_r.release_irq_suppress &&
    (|BTN_RELEASE_I || (cfg2_r.group_separate_mode &&
    |(fall & MID_SENSOR_MASK)));
  assign ev_btn = |BTN_PRESS_I || |BTN_REPEAT_I;
  assign ev_grp = cfg2_r.group_separate_mode &&
    (|rise || |ev_end_rpt);
  assign ev_slide = slide_start || ev_slide_rpt || ev_extra;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) IRQ_O <= 1'b0;
    else IRQ_O <= ev_btn || ev_rel || ev_grp || ev_slide;
  end

  // Sticky status; a new event wins over a clear in the same cycle.
  logic [1:0] end_hit;
  assign end_hit = TAP_I | HOLD_I;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      BTN2_STATUS_O <= '0;
      DOWN_FLAG_O <= 1'b0;
      UP_FLAG_O <= 1'b0;
      TAP_FLAG_O <= 1'b0;
      PRESS_HOLD_FLAG_O <= 1'b0;
    end else begin
      BTN2_STATUS_O <= (FLAG_CLR_I ? '0 : BTN2_STATUS_O) |
        (cfg2_r.group_separate_mode ? rise : 7'h00);
      DOWN_FLAG_O <= (DOWN_FLAG_O && !FLAG_CLR_I) ||
        (cfg2_r.group_separate_mode && end_hit[0]);
      UP_FLAG_O <= (UP_FLAG_O && !FLAG_CLR_I) ||
        (cfg2_r.group_separate_mode && end_hit[1]);
      TAP_FLAG_O <= (TAP_FLAG_O && !FLAG_CLR_I) || |TAP_I;
      PRESS_HOLD_FLAG_O <= (PRESS_HOLD_FLAG_O && !FLAG_CLR_I) || |HOLD_I;
    end
  end

  // Noise reporting, touch blocking and calibration retry.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      NOISE_STATUS_O <= '0;
      TOUCH_BLOCK_O <= '0;
      CAL_RETRY_O <= 1'b0;
    end else begin
      NOISE_STATUS_O <= NOISE_I.rf |
        (cfg2_r.rf_only_noise_report ? 8'h00 : NOISE_I.lf);
      TOUCH_BLOCK_O <= NOISE_I.lf |
        (cfg2_r.rf_noise_block_disable ? 8'h00 : NOISE_I.rf);
      CAL_RETRY_O <= CAL_RF_I && !cfg2_r.rf_noise_block_disable;
    end
  end

  // Mirror bits follow polarity edges unless decoupled.
  logic [10:0] pol_q_r;
  logic [10:0] pol_chg;
  assign pol_chg = LED_POL_I ^ pol_q_r;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      pol_q_r <= '0;
      LED_MIRROR_O <= '0;
    end else begin
      pol_q_r <= LED_POL_I;
      if (!cfg2_r.mirror_polarity_decouple)
        LED_MIRROR_O <= ((MIRROR_WR_I ? MIRROR_WDATA_I : LED_MIRROR_O) &
          ~pol_chg) | (LED_POL_I & pol_chg);
      else if (MIRROR_WR_I) LED_MIRROR_O <= MIRROR_WDATA_I;
    end
  end

  // Mode outputs toward the LED and sensing logic.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESET_N_I) begin
      LINK_INVERT_O <= 1'b0;
      LINK_MIN_EQ_MAX_O <= 1'b0;
      GROUP_SLIDER_O <= 1'b0;
      GROUP_QUEUE_SEL_O <= '0;
    end else begin
      LINK_INVERT_O <= cfg2_r.linked_transition_invert;
      LINK_MIN_EQ_MAX_O <= !cfg2_r.linked_transition_invert;
      GROUP_SLIDER_O <= !cfg2_r.group_separate_mode;
      GROUP_QUEUE_SEL_O <= cfg2_r.group_separate_mode ?
        MID_SENSOR_MASK : 7'h00;
    end
  end

  // Checks.
  recal_clear_a: assert property (
    RECAL_DONE_I[0] && !wr_recal |=> !recal_r[0])
    else $error("recal bit not cleared after done");
  recal_set_a: assert property (
    wr_recal && REG_WDATA_I[7] |=> recal_r[7] && RECAL_REQ_O[7])
    else $error("group recal request not taken");
  extra_cap_a: assert property (
    extra_cnt_r <= $past(slider_cfg_r.max_extra) || $past(ev_extra))
    else $error("extra count above maximum");
  no_extra_a: assert property (
    !slider_cfg_r.accel_extra_irq_enable |=> extra_cnt_r == 3'h0)
    else $error("extra interrupts while disabled");
  slow_slide_a: assert property (
    slide_end && slide_t_r > slide_limit(slider_cfg_r.slide_time)
    |=> extra_cnt_r == 3'h0)
    else $error("slow slide earned extras");
  fast_rpt_a: assert property (
    speed_r >= 4'h5 |-> rpt_per == RPT_W'(RPT_BASE_POLLS))
    else $error("fast slide period wrong");
  rel_irq_a: assert property (
    cfg2_r.release_irq_suppress |-> !ev_rel)
    else $error("release interrupt while suppressed");
  noise_rf_a: assert property (
    cfg2_r.rf_only_noise_report && $stable(cfg2_r)
    |=> NOISE_STATUS_O == $past(NOISE_I.rf))
    else $error("noise status not rf only");
  block_rf_a: assert property (
    !cfg2_r.rf_noise_block_disable ##1 1
    |-> (TOUCH_BLOCK_O & $past(NOISE_I.rf)) == $past(NOISE_I.rf))
    else $error("rf noise did not block touch");
  mirror_follow_a: assert property (
    !cfg2_r.mirror_polarity_decouple && pol_chg[0]
    |=> LED_MIRROR_O[0] == $past(LED_POL_I[0]))
    else $error("mirror did not follow polarity");
  irq_touch_a: assert property (
    cfg2_r.group_separate_mode && rise[3] |=> IRQ_O && BTN2_STATUS_O[3])
    else $error("separate sensor touch lost");
endmodule

// >>> verilog/tse_pkg.sv
package tse_pkg;
  // Register map and reset values.
  localparam logic [7:0] ADDR_SLIDER = 8'h3e;
  localparam logic [7:0] ADDR_RECAL = 8'h3f;
  localparam logic [7:0] ADDR_CFG2 = 8'h40;
  localparam logic [7:0] RST_SLIDER = 8'hc5;
  localparam logic [7:0] RST_RECAL = 8'h00;
  localparam logic [7:0] RST_CFG2 = 8'h00;
  localparam logic [7:0] CFG2_MASK = 8'h9f;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // Grouped sensors nine to thirteen sit in bits 1..5 of the group vector.
  localparam logic [6:0] MID_SENSOR_MASK = 7'h3e;
  localparam int FIRST_IDX = 0;
  localparam int LAST_IDX = 6;
  // Timing: the polling cycle is the unit of every slider count.
  localparam int CLK_HZ = 250_000_000;
  localparam int POLL_MS = 35;
  localparam int POLL_CYCLES = CLK_HZ / 1000 * POLL_MS;
  localparam int SPEED_WIN_MS = 100;
  localparam int SPEED_WIN_POLLS = (SPEED_WIN_MS + POLL_MS / 2) / POLL_MS;
  localparam int RPT_BASE_MS = 35;
  localparam int RPT_BASE_POLLS = RPT_BASE_MS / POLL_MS;
  localparam int FAST_LIMIT_MS = 105;
  localparam int FAST_LIMIT_POLLS = FAST_LIMIT_MS / POLL_MS;
  localparam int SLIDE_00_MS = 350;
  localparam int SLIDE_01_MS = 560;
  localparam int SLIDE_10_MS = 770;
  localparam int SLIDE_11_MS = 980;
  localparam int SLIDE_CNT_W = 6;
  localparam int SPEED_W = 4;
  localparam int RPT_W = 4;

  typedef struct packed {
    logic accel_extra_irq_enable;
    logic [2:0] max_extra;
    logic [1:0] slide_time;
    logic [1:0] repeat_speed_scale;
  } tse_slider_cfg_t;

  typedef struct packed {
    logic linked_transition_invert;
    logic [1:0] rsvd;
    logic mirror_polarity_decouple;
    logic rf_only_noise_report;
    logic rf_noise_block_disable;
    logic group_separate_mode;
    logic release_irq_suppress;
  } tse_cfg2_t;

  typedef struct packed {
    logic [7:0] rf;
    logic [7:0] lf;
  } tse_noise_t;
endpackage
